// ==== rtl/css_core.sv ====
// CPU status word, stack pointer and register banks behind APB
`timescale 1ns/1ps
`include "css_defines.svh"
module css_core #(
    parameter int NBANK = 4,
    parameter int NREG  = 8
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic      [7:0]  status_o,
    output logic      [15:0] sp_o,
    output logic      [1:0]  bank_o,
    output logic             irq_accept_o
);
    import css_pkg::*;

    initial begin
        if (NBANK != 4 || NREG != 8)
            $error("css_core supports four banks of eight registers");
    end

    // ==========================================================
    // State
    logic [7:0]  status_q, status_d;
    logic [15:0] sp_q, sp_d;
    logic [7:0]  bank_mem [0:31];
    logic [7:0]  stack_mem [0:255];
    logic [7:0]  irq_q;
    logic [15:0] alu_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, accept_q;

    // ==========================================================
    // Bus decode
    // Read data is latched on the first access edge, writes land on the last
    wire         acc      = psel_i && penable_i && !pready_q;
    wire         done     = psel_i && penable_i && pready_q;
    wire         rd       = acc && !pwrite_i;
    wire         in_bank  = paddr_i >= `CSS_OFS_BANKBASE &&
                            paddr_i <= `CSS_OFS_BANKEND;
    wire [4:0]   bidx     = paddr_i[6:2];
    wire         hit_st   = paddr_i == `CSS_OFS_STATUS;
    wire         hit_sp   = paddr_i == `CSS_OFS_SP;
    wire         hit_cmd  = paddr_i == `CSS_OFS_CMD;
    wire         hit_top  = paddr_i == `CSS_OFS_STACKTOP;
    wire         hit_req  = paddr_i == `CSS_OFS_IRQREQ;
    wire         hit_res  = paddr_i == `CSS_OFS_IRQRES;
    wire         hit_alu  = paddr_i == `CSS_OFS_ALU;
    wire         mapped   = hit_st | hit_sp | hit_cmd | hit_top | hit_req |
                            hit_res | hit_alu | in_bank | paddr_i[1:0] != 2'h0;
    wire         ok       = mapped && paddr_i[1:0] == 2'h0;
    wire         wr       = done && pwrite_i && ok;
    wire         cmd_go   = wr && hit_cmd;
    css_cmd_e    cmd;
    assign cmd = css_cmd_e'(pwdata_i[3:0]);
    wire [2:0]   bitn     = pwdata_i[10:8];
    wire [1:0]   selbank  = pwdata_i[9:8];

    // Interrupt decision from request word
    css_irq_s    irq;
    assign irq = css_irq_s'(pwdata_i[11:8]);
    wire         ie       = status_q[`CSS_BIT_IE];
    wire         ilf      = status_q[`CSS_BIT_ILF];
    wire         pri_ok   = irq.high_pri || ilf; // RQ8
    wire         vec_ok   = ie && !irq.masked && pri_ok; // RQ14
    wire         do_nmi   = irq.nmi; // RQ13
    wire         do_macro = !irq.nmi && irq.macro && !irq.masked; // RQ13
    wire         do_vec   = !irq.nmi && !irq.macro && vec_ok;
    wire         ack_go   = cmd_go && cmd == CSS_CMD_ACK;
    wire         push_go  = cmd_go && (cmd == CSS_CMD_PUSH ||
                            cmd == CSS_CMD_BRK ||
                            (cmd == CSS_CMD_ACK && (do_nmi || do_vec))); // RQ3
    wire         pop_go   = cmd_go && (cmd == CSS_CMD_POP ||
                            cmd == CSS_CMD_RETURN_FROM_INTERRUPT ||
                            cmd == CSS_CMD_RETURN_FROM_BREAK); // RQ4

    // Flag update from an operation result
    function automatic logic [7:0] css_alu(input logic [7:0] s,
                                           input logic [31:0] w);
        logic [7:0] r;
        r = s;
        r[`CSS_BIT_Z]  = w[15:8] == 8'h00; // RQ12
        r[`CSS_BIT_AC] = w[16]; // RQ11
        r[`CSS_BIT_CY] = w[17]; // RQ6
        return r;
    endfunction

    // Status value as stored, fixed bit forced low
    function automatic logic [7:0] css_keep(input logic [7:0] v);
        return v & `CSS_STATUS_WMASK;
    endfunction

    wire [7:0]  top_byte = stack_mem[sp_q[7:0]];

    wire [15:0] sp_dec = sp_q - 16'h0001;
    wire [15:0] sp_inc = sp_q + 16'h0001;
    wire [4:0]  wpair  = {~status_q[`CSS_BIT_BSH], ~status_q[`CSS_BIT_BSL],
                          3'h0}; // RQ9 RQ19

    // ==========================================================
    // Status and stack pointer next values
    always_comb begin
        status_d = status_q;
        sp_d     = sp_q;
        if (wr && hit_st)
            status_d = css_keep(pwdata_i[7:0]); // RQ2
        if (wr && hit_sp)
            sp_d = pwdata_i[15:0]; // RQ17
        if (wr && hit_alu)
            status_d = css_alu(status_q, pwdata_i);
        if (cmd_go) begin
            case (cmd)
                CSS_CMD_EI:     status_d[`CSS_BIT_IE] = 1'b1; // RQ15
                CSS_CMD_DI:     status_d[`CSS_BIT_IE] = 1'b0; // RQ15
                CSS_CMD_SEL: begin
                    status_d[`CSS_BIT_BSH] = selbank[1]; // RQ10
                    status_d[`CSS_BIT_BSL] = selbank[0]; // RQ10
                end
                CSS_CMD_BITSET: if (bitn != 3'd2) status_d[bitn] = 1'b1; // RQ2
                CSS_CMD_BITCLR: status_d[bitn] = 1'b0; // RQ2
                CSS_CMD_ACK: begin
                    if (do_nmi || do_vec)
                        status_d[`CSS_BIT_IE] = 1'b0; // RQ15
                    if (do_nmi)
                        status_d[`CSS_BIT_ILF] = 1'b0; // RQ7
                    else if (do_vec)
                        status_d[`CSS_BIT_ILF] = !irq.high_pri; // RQ7
                end
                CSS_CMD_POP, CSS_CMD_RETURN_FROM_INTERRUPT, CSS_CMD_RETURN_FROM_BREAK:
                    status_d = css_keep(top_byte); // RQ4
                default: ;
            endcase
            if (push_go)
                sp_d = sp_dec; // RQ16
            else if (pop_go)
                sp_d = sp_inc; // RQ16
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            status_q <= `CSS_STATUS_RST; // RQ5 RQ20
            irq_q    <= 8'h00;
        end else begin
            status_q <= status_d;
            if (ack_go)
                irq_q <= {5'h0, do_macro, do_vec, do_nmi};
        end
    end

    // Stack pointer has no reset value
    always_ff @(posedge sys_clk_i) begin
        sp_q <= sp_d; // RQ17
        if (push_go)
            stack_mem[sp_dec[7:0]] <= status_q; // RQ3
    end

    // Bank memory, byte addressed, words as pairs
    always_ff @(posedge sys_clk_i) begin
        if (wr && in_bank)
            bank_mem[bidx] <= pwdata_i[7:0]; // RQ18 RQ21 RQ22
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            alu_q <= 16'h0000;
        end else if (wr && hit_alu) begin
            alu_q <= pwdata_i[15:0];
        end
    end

    // ==========================================================
    // Read path
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        if (hit_st)  rmux = {24'h0, status_q}; // RQ1 RQ10
        if (hit_sp)  rmux = {16'h0, sp_q};
        if (hit_top) rmux = {24'h0, top_byte};
        if (hit_res) rmux = {24'h0, irq_q};
        if (hit_alu) rmux = {16'h0, alu_q};
        if (hit_req) rmux = {16'h0, bank_mem[wpair + 5'd1],
                             bank_mem[wpair]}; // RQ22
        if (in_bank) rmux = {24'h0, bank_mem[bidx]}; // RQ21
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            accept_q  <= 1'b0;
        end else begin
            pready_q  <= psel_i && penable_i && !pready_q;
            pslverr_q <= acc && !ok;
            accept_q  <= ack_go && (do_nmi || do_vec || do_macro);
            if (rd)
                prdata_q <= ok ? rmux : 32'h0000_0000;
        end
    end

    assign prdata_o     = prdata_q;
    assign pready_o     = pready_q;
    assign pslverr_o    = pslverr_q;
    assign status_o     = status_q;
    assign sp_o         = sp_q;
    assign bank_o       = {status_q[`CSS_BIT_BSH], status_q[`CSS_BIT_BSL]};
    assign irq_accept_o = accept_q;

    // ==========================================================
    // Checks
    chk_fixed_zero: assert property ( // RQ1
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !status_q[`CSS_BIT_FIX])
        else $error("status fixed bit not zero");

    chk_reset_val: assert property ( // RQ5
        @(posedge sys_clk_i)
        $past(sys_rst_i)
        |-> status_q == `CSS_STATUS_RST)
        else $error("status reset value wrong");

    chk_bank_reset: assert property ( // RQ20
        @(posedge sys_clk_i)
        $past(sys_rst_i)
        |-> bank_o == 2'h0)
        else $error("reset did not pick bank zero");

    chk_push_sp: assert property ( // RQ16
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        push_go
        |=> sp_q == $past(sp_q) - 16'h0001)
        else $error("push did not predecrement");

    chk_pop_sp: assert property ( // RQ16
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        pop_go
        |=> sp_q == $past(sp_q) + 16'h0001)
        else $error("pop did not postincrement");

    chk_push_data: assert property ( // RQ3
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        push_go
        |=> top_byte == $past(status_q))
        else $error("push did not store status");

    chk_nmi_push: assert property ( // RQ3
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && do_nmi
        |=> sp_q == $past(sp_q) - 16'h0001)
        else $error("nmi did not push status");

    chk_pop_restore: assert property ( // RQ4
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        pop_go
        |=> status_q == css_keep($past(top_byte)))
        else $error("pop did not restore status");

    chk_ack_ie: assert property ( // RQ15
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && (do_nmi || do_vec)
        |=> !status_q[`CSS_BIT_IE] && irq_accept_o)
        else $error("acknowledge left enable set");

    chk_ei_set: assert property ( // RQ15
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_go && cmd == CSS_CMD_EI
        |=> status_q[`CSS_BIT_IE])
        else $error("enable instruction left flag clear");

    chk_di_clear: assert property ( // RQ15
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_go && cmd == CSS_CMD_DI
        |=> !status_q[`CSS_BIT_IE])
        else $error("disable instruction left flag set");

    chk_nmi_level: assert property ( // RQ7
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && do_nmi
        |=> !status_q[`CSS_BIT_ILF])
        else $error("nmi left level flag set");

    chk_vec_level: assert property ( // RQ7
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && do_vec
        |=> status_q[`CSS_BIT_ILF] == !$past(irq.high_pri))
        else $error("level flag not copied from priority");

    chk_low_refuse: assert property ( // RQ8
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && !ilf && !irq.high_pri && !irq.nmi && !irq.macro
        |=> status_q == $past(status_q))
        else $error("low priority accepted at level zero");

    chk_high_accept: assert property ( // RQ8
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && ie && !irq.nmi && !irq.macro && !irq.masked && irq.high_pri
        |=> irq_accept_o)
        else $error("high priority request refused");

    chk_low_accept: assert property ( // RQ8
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && ie && ilf && !irq.nmi && !irq.macro && !irq.masked
        |=> irq_accept_o)
        else $error("low priority refused at level one");

    chk_ie_off: assert property ( // RQ13
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && !ie && !irq.nmi
        |=> sp_q == $past(sp_q))
        else $error("vectored accepted while disabled");

    chk_off_quiet: assert property ( // RQ13
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && !ie && !irq.nmi && (!irq.macro || irq.masked)
        |=> !irq_accept_o)
        else $error("request accepted while disabled");

    chk_macro_quiet: assert property ( // RQ13
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && do_macro
        |=> sp_q == $past(sp_q) && status_q == $past(status_q))
        else $error("macro service touched status or stack");

    chk_vec_gate: assert property ( // RQ14
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_go && !irq.nmi && !irq.macro && !vec_ok
        |=> status_q == $past(status_q))
        else $error("gated request changed status");

    chk_sel_bank: assert property ( // RQ10
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_go && cmd == CSS_CMD_SEL
        |=> bank_o == $past(selbank))
        else $error("bank choose not applied");

    chk_status_write: assert property ( // RQ2
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wr && hit_st
        |=> status_q == css_keep($past(pwdata_i[7:0])))
        else $error("status write not applied");

    chk_bit_set: assert property ( // RQ2
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_go && cmd == CSS_CMD_BITSET && bitn != 3'h2
        |=> status_q == ($past(status_q) | (8'h01 << $past(bitn))))
        else $error("bit set not applied");

    chk_bit_clear: assert property ( // RQ2
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_go && cmd == CSS_CMD_BITCLR
        |=> status_q == ($past(status_q) & ~(8'h01 << $past(bitn))))
        else $error("bit clear not applied");

    chk_alu_flags: assert property ( // RQ6 RQ11 RQ12
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wr && hit_alu
        |=> status_q == css_alu($past(status_q), $past(pwdata_i)))
        else $error("result flags not updated");

    chk_bank_write: assert property ( // RQ21
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wr && in_bank
        |=> bank_mem[$past(bidx)] == $past(pwdata_i[7:0]))
        else $error("bank byte write lost");

    cov_push: cover property (@(posedge sys_clk_i) push_go);
    cov_vec:  cover property (@(posedge sys_clk_i)
        ack_go && do_vec && !irq.high_pri);
    cov_nmi:  cover property (@(posedge sys_clk_i) ack_go && do_nmi);
    cov_sel:  cover property (@(posedge sys_clk_i)
        cmd_go && cmd == CSS_CMD_SEL && selbank == 2'h3);
    cov_bank: cover property (@(posedge sys_clk_i) wr && in_bank);
endmodule // css_core

// ==== rtl/css_defines.svh ====
// Constants for the CPU status, stack and register bank block
// Functional notes
// RQ1 - Status byte layout: IE Z BSH AC BSL 0 ILF CY
// RQ2 - Status byte accessible whole or per bit
// RQ3 - Push status on interrupt, break, push
// RQ4 - Pop status on return or status pop
// RQ5 - Status resets to 02H, interrupts off
// RQ6 - Carry from arithmetic, shifts, bit logic
// RQ7 - Acknowledge copies priority; NMI clears level
// RQ8 - Level zero refuses low priority requests
// RQ9 - Bank flags high,low pick bank binary
// RQ10 - Bank choose writes flags; reading returns bank
// RQ11 - Aux carry from bit 3 carry/borrow
// RQ12 - Zero flag set when result zero
// RQ13 - Enable clear: only NMI and macro service
// RQ14 - Enable set: mask, priority, level decide
// RQ15 - On sets enable; off or acknowledge clears
// RQ16 - Stack pointer predecrement push, postincrement pop
// RQ17 - Stack pointer undefined until software loads
// RQ18 - Bank RAM spans 0FEE0H to 0FEFFH
// RQ19 - Bank 0 at F8H, higher banks lower
// RQ20 - Reset selects bank 0
// RQ21 - Bank region also plain data memory
// RQ22 - Registers usable as bytes or word pairs
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH
// ==========================================================
// Register offsets (APB byte addresses)
`define CSS_OFS_STATUS   12'h000
`define CSS_OFS_SP       12'h004
`define CSS_OFS_CMD      12'h008
`define CSS_OFS_STACKTOP 12'h00C
`define CSS_OFS_IRQREQ   12'h010
`define CSS_OFS_IRQRES   12'h014
`define CSS_OFS_ALU      12'h018
`define CSS_OFS_BANKBASE 12'h100
`define CSS_OFS_BANKEND  12'h17C
// ==========================================================
// Status bit positions
`define CSS_BIT_IE  7
`define CSS_BIT_Z   6
`define CSS_BIT_BSH 5
`define CSS_BIT_AC  4
`define CSS_BIT_BSL 3
`define CSS_BIT_FIX 2
`define CSS_BIT_ILF 1
`define CSS_BIT_CY  0
`define CSS_STATUS_RST 8'h02
`define CSS_STATUS_WMASK 8'hFB
// ==========================================================
// Register bank memory
`define CSS_BANK_BASE 16'hFEE0
`define CSS_BANK_TOP  16'hFEFF
`define CSS_BANK0_LO  8'hF8
`endif

// ==== rtl/css_pkg.sv ====
// Types for the CPU status, stack and register bank block
package css_pkg;
    typedef enum logic [3:0] {
        CSS_CMD_NONE, CSS_CMD_PUSH, CSS_CMD_POP, CSS_CMD_BRK,
        CSS_CMD_RETURN_FROM_INTERRUPT, CSS_CMD_RETURN_FROM_BREAK, CSS_CMD_EI, CSS_CMD_DI,
        CSS_CMD_SEL, CSS_CMD_BITSET, CSS_CMD_BITCLR, CSS_CMD_ALU,
        CSS_CMD_ACK
    } css_cmd_e;
    typedef enum logic [1:0] {
        CSS_IDLE, CSS_PUSH, CSS_POP
    } css_state_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } css_mem_s;
    typedef struct packed {
        logic       nmi;
        logic       macro;
        logic       masked;
        logic       high_pri;
    } css_irq_s;
endpackage

// ==== verif/css_core_tb.sv ====
// Self-checking bench for the CPU status, stack and bank block
`timescale 1ns/1ps
`include "css_defines.svh"
module css_core_tb;
    import css_pkg::*;
    // ==========================================================
    // Signals and models
    logic        sys_clk_i, sys_rst_i, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, r_x;
    logic        e_x;
    logic        pready, pslverr, irq_acc;
    logic [7:0]  status, st;
    logic [15:0] sp, spm;
    logic [1:0]  bank;
    logic [7:0]  stk [256];
    logic [7:0]  ram [32];
    int          mismatches, checks_done;

    css_core dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .status_o(status),
        .sp_o(sp), .bank_o(bank), .irq_accept_o(irq_acc));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task finish_test;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(negedge sys_clk_i);
        while (pready !== 1'b1 && n < 16) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (pready !== 1'b1) begin
            mismatches++;
            finish_test();
        end
        r = prdata;
        e = pslverr;
        @(posedge sys_clk_i);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        check("write_err", {31'h0, e}, 32'h0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check("read_data", r, exp);
        check("read_err", {31'h0, e}, {31'h0, ee});
    endtask
    task push;
        spm = spm - 16'h1;
        stk[spm[7:0]] = st;
    endtask
    task stchk;
        @(negedge sys_clk_i);
        check("status", {24'h0, status}, {24'h0, st});
        check("bank", {30'h0, bank}, {30'h0, st[5], st[3]});
        check("sp", {16'h0, sp}, {16'h0, spm});
    endtask
    task cmd(input css_cmd_e c, input logic [3:0] a);
        int k;
        logic acc;
        logic [2:0] res;
        k = 0;
        acc = 1'b0;
        res = 3'h0;
        case (c)
            CSS_CMD_PUSH, CSS_CMD_BRK: push();
            CSS_CMD_POP, CSS_CMD_RETURN_FROM_INTERRUPT, CSS_CMD_RETURN_FROM_BREAK: begin
                st = stk[spm[7:0]];
                spm = spm + 16'h1;
            end
            CSS_CMD_EI: st[7] = 1'b1;
            CSS_CMD_DI: st[7] = 1'b0;
            CSS_CMD_SEL: {st[5], st[3]} = a[1:0];
            CSS_CMD_BITSET: if (a[2:0] != 3'h2) st[a[2:0]] = 1'b1;
            CSS_CMD_BITCLR: st[a[2:0]] = 1'b0;
            CSS_CMD_ACK: begin
                if (a[3]) begin
                    acc = 1'b1;
                    res = 3'h1;
                    push();
                    st[1] = 1'b0;
                    st[7] = 1'b0;
                end else if (a[2]) begin
                    acc = !a[1];
                    res = {acc, 2'h0};
                end else if (st[7] && !a[1] && (a[0] || st[1])) begin
                    acc = 1'b1;
                    res = 3'h2;
                    push();
                    st[1] = !a[0];
                    st[7] = 1'b0;
                end
            end
            default: ;
        endcase
        wr(`CSS_OFS_CMD, {20'h0, a, 4'h0, c});
        repeat (3) begin
            @(negedge sys_clk_i);
            if (irq_acc === 1'b1) k++;
        end
        check("irq_accept", 32'(k), {31'h0, acc});
        stchk();
        if (c == CSS_CMD_ACK) rd(`CSS_OFS_IRQRES, {29'h0, res}, 1'b0);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        mismatches = 0; checks_done = 0; rnd = 32'h7E7314A6;
        sys_rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        check("reset_status", {24'h0, status}, 32'h02);
        check("reset_bank", {30'h0, bank}, 32'h0);
        rd(`CSS_OFS_STATUS, 32'h02, 1'b0);
        spm = `CSS_BANK_BASE;
        wr(`CSS_OFS_SP, {16'h0, spm});
        rd(`CSS_OFS_SP, {16'h0, spm}, 1'b0);
        st = 8'h02;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(`CSS_OFS_STATUS, {24'h0, rnd[7:0]});
            st = rnd[7:0] & `CSS_STATUS_WMASK;
            rd(`CSS_OFS_STATUS, {24'h0, st}, 1'b0);
            stchk();
            cmd(CSS_CMD_BITSET, 4'(i));
            cmd(CSS_CMD_BITCLR, 4'(i));
        end
        for (int b = 0; b < 4; b++) cmd(CSS_CMD_SEL, 4'(b));
        cmd(CSS_CMD_NONE, 4'h0);
        cmd(CSS_CMD_EI, 4'h0);
        cmd(CSS_CMD_PUSH, 4'h0);
        rd(`CSS_OFS_STACKTOP, {24'h0, stk[spm[7:0]]}, 1'b0);
        cmd(CSS_CMD_DI, 4'h0);
        cmd(CSS_CMD_BRK, 4'h0);
        wr(`CSS_OFS_STATUS, 32'h0);
        st = 8'h00;
        cmd(CSS_CMD_RETURN_FROM_BREAK, 4'h0);
        cmd(CSS_CMD_RETURN_FROM_INTERRUPT, 4'h0);
        cmd(CSS_CMD_PUSH, 4'h0);
        cmd(CSS_CMD_POP, 4'h0);
        for (int j = 0; j < 32; j++) begin
            rnd = lfsr(rnd);
            wr(`CSS_OFS_STATUS, {24'h0, rnd[7:0]});
            st = rnd[7:0] & `CSS_STATUS_WMASK;
            cmd(CSS_CMD_ACK, 4'(j));
        end
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            if (i == 0) rnd[15:8] = 8'h00;
            wr(`CSS_OFS_ALU, {14'h0, rnd[17:8], 8'h0});
            st[6] = (rnd[15:8] == 8'h00);
            st[4] = rnd[16];
            st[0] = rnd[17];
            stchk();
            rd(`CSS_OFS_ALU, {16'h0, rnd[15:8], 8'h00}, 1'b0);
        end
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            ram[i] = rnd[7:0];
            wr(`CSS_OFS_BANKBASE + 12'(4 * i), {24'h0, ram[i]});
            rd(`CSS_OFS_BANKBASE + 12'(4 * i), {24'h0, ram[i]}, 1'b0);
        end
        for (int b = 0; b < 4; b++) begin
            cmd(CSS_CMD_SEL, 4'(b));
            rd(`CSS_OFS_IRQREQ, {16'h0, ram[25 - 8 * b], ram[24 - 8 * b]},
               1'b0);
        end
        rd(12'h020, 32'h0, 1'b1);
        apb(1'b1, 12'h101, {24'h0, ~ram[0]}, r_x, e_x);
        check("refused_err", {31'h0, e_x}, 32'h1);
        rd(`CSS_OFS_BANKBASE, {24'h0, ram[0]}, 1'b0);
        stchk();
        finish_test();
    end
endmodule // css_core_tb
